// *** verilog/tbmr_pkg.sv ***
// Package: timing constants and register map of the tape mark recognizer
package tbmr_pkg;
  // Clock rate in kHz (25 MHz)
  localparam int CLK_KHZ = 25000;
  // Times in nanoseconds
  localparam int STRETCH_NS = 4000;
  localparam int WINDOW_NS = 10000;
  localparam int GAP_NS = 15000;
  localparam int MARK_SPACING_NS = 11000;
  localparam int SPROCKET_SPACING_NS = 22000;
  // Cycle counts; stretch and window round down, gap limit rounds down
  localparam int STRETCH_CYC = (STRETCH_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int WINDOW_CYC = (WINDOW_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int GAP_CYC = (GAP_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int TMR_W = 10;
  // Mark counter
  localparam int CNT_W = 5;
  localparam int MARK_SEEN_BIT = 3;
  localparam int MARK_FULL_BIT = 4;
  localparam logic [4:0] SEEN_COUNT = 5'h08;
  localparam logic [4:0] FULL_COUNT = 5'h18;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  // Control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_BEGIN_DONE = 1;
  localparam int CTRL_CLEAR = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int EV_SEEN = 0;
  localparam int EV_INTACT = 1;
  localparam int EV_FMT_ERR = 2;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// *** verilog/tbmr_pulse_sync.sv ***
// Three-flop synchroniser with rising-edge pulse for the read channel
`timescale 1ns/1ps
`default_nettype none
module tbmr_pulse_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Raw pin and synchronous edge
  input wire logic pinIn,
  output logic risePulse
);
  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic level_ff;
  logic nxt_level;

  ////////////////////////////////////////////////////////////////////////
  // Level changes only when the second and third stages agree
  always_comb begin
    nxt_sync = {sync_ff[1:0], pinIn};
    nxt_level = level_ff;
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_level = sync_ff[2];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_ff <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      sync_ff <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  // Rising edge of the filtered level
  assign risePulse = nxt_level & ~level_ff;
endmodule
`default_nettype wire

// *** verilog/tbmr_timer.sv ***
// Retriggerable down-counter standing in for a one-shot
`timescale 1ns/1ps
`default_nettype none
module tbmr_timer #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic fire,
  input wire logic [W-1:0] len,
  // State
  output logic running
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Load on fire, otherwise count down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (fire) begin
      nxt_cnt = len;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign running = (cnt_ff != '0);
endmodule
`default_nettype wire

// *** verilog/tbmr_mark_recognizer.sv ***
// Block mark and sprocket recognizer with AHB-Lite registers
//
// Behaviour
// R1: Separate mark from sprocket pulses by spacing
// R2: Beginning and end marks tested alike
// R3: Nine contiguous pulses accept a mark
// R4: Sixteen more contiguous pulses make it intact
// R5: Accepted but not intact flags format error
// R6: Windowless pulse clears the counter
// R7: Clear held for the whole stretch
// R8: Counting window opens after stretch ends
// R9: Windows alternate by counter lowest bit
// R10: Bit three set signals mark received
// R11: Bits three and four signal intact mark
// R12: Gap over 15 us clears counter
// R13: Sprockets pass only while window flag set
// R14: Seen at eight, incomplete cleared at 24
// R15: Sprockets inhibited until beginning mark done
// R16: Synchronise input, time with clock counters
`timescale 1ns/1ps
`default_nettype none
module tbmr_mark_recognizer #(
  parameter int TMR_W = tbmr_pkg::TMR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Read head channel
  input wire logic headPulse,
  // Assembly unit side
  output logic markSeen,
  output logic markIntact,
  output logic formatError,
  output logic sprocketPulse,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Input edge detection
  logic pulseEdge;

  tbmr_pulse_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(headPulse),
    .risePulse(pulseEdge)
  ); // [R16]

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [2:0] ctrl_ff, nxt_ctrl;
  logic [tbmr_pkg::IRQ_W-1:0] irqStat_ff, nxt_irqStat;
  logic [tbmr_pkg::IRQ_W-1:0] irqEn_ff, nxt_irqEn;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic irq_ff, nxt_irq;
  logic wrPend_ff, nxt_wrPend;
  logic [7:0] wrAddr_ff, nxt_wrAddr;

  // Recognizer state
  logic [tbmr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic clrHold_ff, nxt_clrHold;
  logic stretchRun_d_ff;
  logic seen_ff, nxt_seen;
  logic intact_ff, nxt_intact;
  logic incomplete_ff, nxt_incomplete;
  logic fmtErr_ff, nxt_fmtErr;
  logic sprWin_ff, nxt_sprWin;
  logic sprOut_ff, nxt_sprOut;
  logic [TMR_W-1:0] gap_ff, nxt_gap;
  logic gapStale_ff, nxt_gapStale;

  logic stretchRun, evenRun, oddRun;
  logic stretchEnd, windowOpen, fireEven, fireOdd;
  logic enable, beginDone, swClear;
  logic evSeen, evIntact, evFmt;

  assign enable = ctrl_ff[tbmr_pkg::CTRL_ENABLE];
  assign beginDone = ctrl_ff[tbmr_pkg::CTRL_BEGIN_DONE];
  assign swClear = ctrl_ff[tbmr_pkg::CTRL_CLEAR];

  ////////////////////////////////////////////////////////////////////////
  // Three one-shot replacements
  tbmr_timer #(.W(TMR_W)) u_stretch (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fire(pulseEdge & enable),
    .len(TMR_W'(tbmr_pkg::STRETCH_CYC)),
    .running(stretchRun)
  ); // [R16]

  // Stretch end arms one window, picked by counter bit zero
  assign stretchEnd = stretchRun_d_ff & ~stretchRun;
  assign fireEven = stretchEnd & ~cnt_ff[0]; // [R9]
  assign fireOdd = stretchEnd & cnt_ff[0]; // [R9]

  tbmr_timer #(.W(TMR_W)) u_even (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fire(fireEven),
    .len(TMR_W'(tbmr_pkg::WINDOW_CYC)),
    .running(evenRun)
  ); // [R8]

  tbmr_timer #(.W(TMR_W)) u_odd (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fire(fireOdd),
    .len(TMR_W'(tbmr_pkg::WINDOW_CYC)),
    .running(oddRun)
  ); // [R8]

  // Either window open lets a pulse count; 11 us marks land inside,
  // 22 us sprockets fall outside and clear
  assign windowOpen = evenRun | oddRun; // [R1]

  ////////////////////////////////////////////////////////////////////////
  // Mark counter and flags; same tests for begin and end marks [R2]
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_clrHold = clrHold_ff;
    nxt_seen = seen_ff;
    nxt_intact = intact_ff;
    nxt_incomplete = incomplete_ff;
    nxt_fmtErr = fmtErr_ff;
    nxt_gap = gap_ff;
    nxt_gapStale = gapStale_ff;
    evSeen = 1'b0;
    evIntact = 1'b0;
    evFmt = 1'b0;
    // Interval since last pulse, saturating
    if (pulseEdge) begin
      nxt_gap = '0;
      nxt_gapStale = 1'b0;
    end else if (gap_ff != TMR_W'(tbmr_pkg::GAP_CYC)) begin
      nxt_gap = gap_ff + 1'b1;
    end else begin
      nxt_gapStale = 1'b1;
    end
    if (!stretchRun) begin
      nxt_clrHold = 1'b0;
    end
    if (pulseEdge && enable) begin
      if (!windowOpen || gapStale_ff) begin
        nxt_cnt = '0; // [R6] [R12]
        nxt_clrHold = 1'b1; // [R7]
      end else if (!clrHold_ff) begin
        nxt_cnt = cnt_ff + 1'b1; // [R8]
      end
    end
    // Held clear overrides any count disturbance
    if (clrHold_ff) begin
      nxt_cnt = '0; // [R7]
    end
    // Nine pulses means counter value 8: bit three set
    if (cnt_ff[tbmr_pkg::MARK_SEEN_BIT] && !seen_ff) begin
      nxt_seen = 1'b1; // [R3] [R10] [R14]
      nxt_incomplete = 1'b1;
      evSeen = 1'b1;
    end
    // Twenty-five pulses means counter value 24: bits three and four
    if (cnt_ff[tbmr_pkg::MARK_SEEN_BIT] && cnt_ff[tbmr_pkg::MARK_FULL_BIT]
        && incomplete_ff) begin
      nxt_incomplete = 1'b0; // [R4] [R11] [R14]
      nxt_intact = 1'b1; // [R11]
      evIntact = 1'b1;
    end
    // Counter fell back before the full mark: format error
    if (seen_ff && incomplete_ff && nxt_cnt == '0 && cnt_ff != '0) begin
      nxt_incomplete = 1'b0;
      nxt_fmtErr = 1'b1; // [R5]
      evFmt = 1'b1;
    end
    if (swClear || !enable) begin
      nxt_cnt = '0;
      nxt_seen = 1'b0;
      nxt_intact = 1'b0;
      nxt_incomplete = 1'b0;
      nxt_fmtErr = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
      clrHold_ff <= 1'b0;
      stretchRun_d_ff <= 1'b0;
      seen_ff <= 1'b0;
      intact_ff <= 1'b0;
      incomplete_ff <= 1'b0;
      fmtErr_ff <= 1'b0;
      gap_ff <= '0;
      gapStale_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      clrHold_ff <= nxt_clrHold;
      stretchRun_d_ff <= stretchRun;
      seen_ff <= nxt_seen;
      intact_ff <= nxt_intact;
      incomplete_ff <= nxt_incomplete;
      fmtErr_ff <= nxt_fmtErr;
      gap_ff <= nxt_gap;
      gapStale_ff <= nxt_gapStale;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sprocket gating: flag set by software once begin mark is processed
  always_comb begin
    nxt_sprWin = enable & beginDone; // [R13] [R15]
    nxt_sprOut = pulseEdge & sprWin_ff & enable; // [R13]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sprWin_ff <= 1'b0;
      sprOut_ff <= 1'b0;
    end else begin
      sprWin_ff <= nxt_sprWin;
      sprOut_ff <= nxt_sprOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  function automatic logic isReg(input logic [7:0] a);
    isReg = (a == tbmr_pkg::ADDR_CTRL) || (a == tbmr_pkg::ADDR_STATUS)
         || (a == tbmr_pkg::ADDR_IRQ_STAT) || (a == tbmr_pkg::ADDR_IRQ_EN)
         || (a == tbmr_pkg::ADDR_IRQ_CLR);
  endfunction

  logic addrOk, rdReq, wrReq;
  logic [tbmr_pkg::IRQ_W-1:0] clrBits, evBits;
  assign addrOk = hsel && hready && htrans[1];
  assign rdReq = addrOk && !hwrite;
  assign wrReq = addrOk && hwrite;
  assign evBits = {evFmt, evIntact, evSeen};

  always_comb begin
    nxt_wrPend = wrReq;
    nxt_wrAddr = wrReq ? haddr[7:0] : wrAddr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_irqEn = irqEn_ff;
    clrBits = '0;
    if (wrPend_ff) begin
      unique case (wrAddr_ff)
        tbmr_pkg::ADDR_CTRL: nxt_ctrl = hwdata[2:0];
        tbmr_pkg::ADDR_IRQ_EN: nxt_irqEn = hwdata[tbmr_pkg::IRQ_W-1:0];
        tbmr_pkg::ADDR_IRQ_CLR: clrBits = hwdata[tbmr_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // Software clear is a self-clearing strobe
    if (swClear && !(wrPend_ff && wrAddr_ff == tbmr_pkg::ADDR_CTRL)) begin
      nxt_ctrl[tbmr_pkg::CTRL_CLEAR] = 1'b0;
    end
    // Set wins over clear
    nxt_irqStat = (irqStat_ff & ~clrBits) | evBits;
    nxt_irq = |(nxt_irqStat & nxt_irqEn);
    nxt_hrdata = tbmr_pkg::RD_ZERO;
    if (rdReq && isReg(haddr[7:0])) begin
      unique case (haddr[7:0])
        tbmr_pkg::ADDR_CTRL: nxt_hrdata = {29'h0, ctrl_ff};
        tbmr_pkg::ADDR_STATUS: nxt_hrdata = {22'h0, cnt_ff, sprWin_ff,
          incomplete_ff, fmtErr_ff, intact_ff, seen_ff};
        tbmr_pkg::ADDR_IRQ_STAT: nxt_hrdata = {29'h0, irqStat_ff};
        tbmr_pkg::ADDR_IRQ_EN: nxt_hrdata = {29'h0, irqEn_ff};
        default: nxt_hrdata = tbmr_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= tbmr_pkg::CTRL_RESET;
      irqStat_ff <= '0;
      irqEn_ff <= '0;
      hrdata_ff <= 32'h00000000;
      irq_ff <= 1'b0;
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      irqStat_ff <= nxt_irqStat;
      irqEn_ff <= nxt_irqEn;
      hrdata_ff <= nxt_hrdata;
      irq_ff <= nxt_irq;
      wrPend_ff <= nxt_wrPend;
      wrAddr_ff <= nxt_wrAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, except hreadyout and hresp, which are tied constant
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign markSeen = seen_ff;
  assign markIntact = intact_ff;
  assign formatError = fmtErr_ff;
  assign sprocketPulse = sprOut_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// *** verification/tbmr_checker.sv ***
// Checker: port-level assertions for the mark recognizer
`timescale 1ns/1ps
`default_nettype none
module tbmr_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Observed ports
  input wire logic headPulse,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic markSeen,
  input wire logic markIntact,
  input wire logic formatError,
  input wire logic sprocketPulse
);
  logic headPrev_ff, nxt_headPrev;
  logic [4:0] sinceRise_ff, nxt_sinceRise;
  // Cycles since the pin last rose; saturates so it never wraps
  always_comb begin
    nxt_headPrev = headPulse;
    nxt_sinceRise = sinceRise_ff;
    if (sinceRise_ff != 5'h1F)
      nxt_sinceRise = sinceRise_ff + 5'h01;
    if (headPulse && !headPrev_ff)
      nxt_sinceRise = 5'h00;
  end
  // Registers of the helper
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      headPrev_ff <= 1'b0;
      sinceRise_ff <= 5'h1F;
    end else begin
      headPrev_ff <= nxt_headPrev;
      sinceRise_ff <= nxt_sinceRise;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Bus never stalls and never errors
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  // Flags rise only on the heels of a pin edge, sync delay included; sprocket single cycle, intact needs seen, no format error while intact
  a_sprk_single: assert property (sprocketPulse |=> !sprocketPulse)
    else $error("sprocket pulse too long");
  a_sprk_cause: assert property (sprocketPulse |-> sinceRise_ff <= 5'h0C)
    else $error("sprocket without pin edge");
  a_seen_cause: assert property ($rose(markSeen) |-> sinceRise_ff <= 5'h0C)
    else $error("seen without pin edge");
  a_intact_cause: assert property ($rose(markIntact) |-> sinceRise_ff <= 5'h0C)
    else $error("intact without pin edge");
  a_intact_seen: assert property (markIntact |-> markSeen)
    else $error("intact without seen");
  a_fmt_cause: assert property ($rose(formatError) |-> !markIntact)
    else $error("format error on intact mark");
  // Main scenarios reached
  c_seen: cover property ($rose(markSeen));
  c_intact: cover property ($rose(markIntact));
  c_fmt: cover property ($rose(formatError));
  c_sprk: cover property (sprocketPulse);
endmodule
bind tbmr_mark_recognizer tbmr_checker chk (.sys_clk(sys_clk),
  .resetn(resetn), .headPulse(headPulse), .hreadyout(hreadyout),
  .hresp(hresp), .markSeen(markSeen), .markIntact(markIntact),
  .formatError(formatError), .sprocketPulse(sprocketPulse));
`default_nettype wire

// *** verification/tbmr_head_model.sv ***
// Read head channel model: pulse trains at a chosen spacing
`timescale 1ns/1ps
`default_nettype none
module tbmr_head_model (
  // Clock
  input wire logic sys_clk,
  // Channel pin, idles low between pulses
  output logic headPulse
);
  initial headPulse = 1'b0;
  // Pulses of four cycles, one every gap cycles
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      headPulse <= 1'b1;
      repeat (4) @(posedge sys_clk);
      headPulse <= 1'b0;
      repeat (gap - 5) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** verification/tbmr_mark_recognizer_test.sv ***
// Testbench: register and pulse-train checks of the mark recognizer
`timescale 1ns/1ps
`default_nettype none
module tbmr_mark_recognizer_test;
  logic sys_clk, resetn, hwrite, headPulse, hreadyout, hresp;
  logic markSeen, markIntact, formatError, sprocketPulse, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdData;
  int errorCnt, samplesChecked, sprCnt;
  // Clock at 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Select and size tied: single word transfers only
  tbmr_mark_recognizer uut (.sys_clk(sys_clk), .resetn(resetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .headPulse(headPulse),
    .markSeen(markSeen), .markIntact(markIntact),
    .formatError(formatError), .sprocketPulse(sprocketPulse), .irq(irq));
  tbmr_head_model head (.sys_clk(sys_clk), .headPulse(headPulse));
  // Count sprocket pulses seen by the assembly side
  always @(posedge sys_clk) if (sprocketPulse === 1'b1) sprCnt++;
  ////////////////////////////////////////
  task automatic finalReport;
    $display("checked %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chkReg(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkPin(input string nm, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask
  // One AHB single: address phase, then data phase; waits on hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rdData);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000, rdData);
    chkReg($sformatf("reg %h", a), e, rdData);
  endtask
  ////////////////////////////////////////
  // Hang guard: the tests take about 17000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    errorCnt++;
    $display("watchdog expired");
    finalReport;
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    errorCnt = 0;
    samplesChecked = 0;
    sprCnt = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdChk(tbmr_pkg::ADDR_CTRL, 32'h00000000);
    rdChk(tbmr_pkg::ADDR_STATUS, 32'h00000000);
    rdChk(tbmr_pkg::ADDR_IRQ_STAT, 32'h00000000);
    rdChk(tbmr_pkg::ADDR_IRQ_EN, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF);
    rdChk(8'h20, 32'h00000000);
    chkPin("irq", 1'b0, irq);
    $display("test reset done");
    wr(tbmr_pkg::ADDR_CTRL, 32'h00000001);
    rdChk(tbmr_pkg::ADDR_CTRL, 32'h00000001);
    head.send(8, 275);
    chkPin("seen8", 1'b0, markSeen);
    head.send(1, 275);
    chkPin("seen9", 1'b1, markSeen);
    rdChk(tbmr_pkg::ADDR_STATUS, 32'h00000109);
    head.send(16, 275);
    chkPin("intact", 1'b1, markIntact);
    chkPin("fmt", 1'b0, formatError);
    rdChk(tbmr_pkg::ADDR_STATUS, 32'h00000303);
    $display("test mark done");
    rdChk(tbmr_pkg::ADDR_IRQ_STAT, 32'h00000003);
    chkPin("irqMasked", 1'b0, irq);
    wr(tbmr_pkg::ADDR_IRQ_EN, 32'h00000001);
    rdChk(tbmr_pkg::ADDR_IRQ_EN, 32'h00000001);
    chkPin("irqOn", 1'b1, irq);
    wr(tbmr_pkg::ADDR_IRQ_CLR, 32'h00000001);
    rdChk(tbmr_pkg::ADDR_IRQ_STAT, 32'h00000002);
    chkPin("irqClr", 1'b0, irq);
    wr(tbmr_pkg::ADDR_IRQ_EN, 32'h00000007);
    rdChk(tbmr_pkg::ADDR_IRQ_CLR, 32'h00000000);
    chkPin("irqIntact", 1'b1, irq);
    wr(tbmr_pkg::ADDR_IRQ_CLR, 32'h00000007);
    rdChk(tbmr_pkg::ADDR_IRQ_STAT, 32'h00000000);
    chkPin("irqOff", 1'b0, irq);
    $display("test irq done");
    wr(tbmr_pkg::ADDR_CTRL, 32'h00000005);
    // Clear strobe stands one cycle after the write; read once it drops
    @(posedge sys_clk);
    rdChk(tbmr_pkg::ADDR_CTRL, 32'h00000001);
    repeat (400) @(posedge sys_clk);
    head.send(9, 275);
    repeat (150) @(posedge sys_clk);
    head.send(1, 275);
    chkPin("fmtGap", 1'b1, formatError);
    chkPin("intactGap", 1'b0, markIntact);
    rdChk(tbmr_pkg::ADDR_IRQ_STAT, 32'h00000005);
    chkPin("irqFmt", 1'b1, irq);
    $display("test format done");
    wr(tbmr_pkg::ADDR_CTRL, 32'h00000005);
    head.send(9, 360);
    chkPin("seenLate", 1'b0, markSeen);
    $display("test window done");
    sprCnt = 0;
    head.send(3, 550);
    chkReg("sprGated", 32'h00000000, 32'(sprCnt));
    wr(tbmr_pkg::ADDR_CTRL, 32'h00000003);
    // Window flag follows the control bit one cycle later
    @(posedge sys_clk);
    rdChk(tbmr_pkg::ADDR_STATUS, 32'h00000010);
    sprCnt = 0;
    head.send(3, 550);
    chkReg("sprOpen", 32'h00000003, 32'(sprCnt));
    chkPin("seenSpr", 1'b0, markSeen);
    $display("test sprocket done");
    finalReport;
  end
endmodule
`default_nettype wire
